// ==== hdl/pps_pkg.sv ====
// shared constants and types for the port shutdown and register control block
package pps_pkg;
  // register offsets, identical in each quad
  localparam logic [7:0] REG_INT_MASK = 8'h01;
  localparam logic [7:0] REG_PWR_STATUS = 8'h10;
  localparam logic [7:0] REG_OP_SELECT = 8'h12;
  localparam logic [7:0] REG_DET_CLASS = 8'h14;
  localparam logic [7:0] REG_PRIO_CUT = 8'h15;
  localparam logic [7:0] REG_MISC = 8'h17;
  localparam logic [7:0] REG_MAN_POWER = 8'h19;
  localparam logic [7:0] REG_LANE_REMAP = 8'h26;
  localparam logic [7:0] REG_POWER_BUDGET = 8'h29;
  localparam logic [7:0] REG_RANK_01 = 8'h2A;
  localparam logic [7:0] REG_RANK_23 = 8'h2B;
  localparam logic [7:0] REG_MEAS_BASE = 8'h30;
  // field layouts and values
  localparam int MISC_CODED_BIT = 0;
  localparam logic [7:0] MISC_MASK = 8'h01;
  localparam logic [7:0] RANK_MASK = 8'h77;
  localparam logic [1:0] MODE_AUTO = 2'h3;
  localparam logic [1:0] ADDR_PREFIX = 2'h1;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] READ_NONE = 8'h00;
  // shutdown code timing at the 40 MHz core clock
  localparam int CLK_PERIOD_NS = 25;
  localparam int T_BIT_NS = 25000;
  localparam int BIT_CYC = T_BIT_NS / CLK_PERIOD_NS;
  localparam logic [10:0] SD_FIRST_WAIT = 11'(BIT_CYC + BIT_CYC / 2 - 1);
  localparam logic [10:0] SD_BIT_WAIT = 11'(BIT_CYC - 1);
  // states
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h0,
    SEQ_PROBE = 2'h1,
    SEQ_FINAL = 2'h2,
    SEQ_ON = 2'h3
  } pps_seq_t;
  typedef enum logic [2:0] {
    LINK_IDLE = 3'h0,
    LINK_RX = 3'h1,
    LINK_ACK_WAIT = 3'h2,
    LINK_ACK = 3'h3,
    LINK_TX = 3'h4,
    LINK_TX_ACK = 3'h5
  } pps_link_t;
endpackage

// ==== hdl/pps_port_if.sv ====
// carrier between the control top and one port sequencer
`timescale 1ns/10ps
interface pps_port_if;
  logic auto_mode;
  logic allow;
  logic power_req;
  logic power_off;
  logic block_on;
  logic class_ok;
  logic fault;
  logic power_on;
  logic probing;
  modport seq (input auto_mode, allow, power_req, power_off, block_on, class_ok, fault,
    output power_on, probing);
  modport ctl (output auto_mode, allow, power_req, power_off, block_on, class_ok, fault,
    input power_on, probing);
endinterface

// ==== hdl/pps_port_seq.sv ====
// per-port detect, classify and power-up sequencer
`timescale 1ns/10ps
module pps_port_seq (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control and status of one port
  pps_port_if.seq p
);
  typedef struct packed {
    pps_pkg::pps_seq_t st;
    logic pwr;
    logic probe;
  } pps_seq_state_t;

  localparam pps_seq_state_t RST_STATE = '{st: pps_pkg::SEQ_IDLE, pwr: 1'b0, probe: 1'b0};

  pps_seq_state_t r;
  pps_seq_state_t n;

  always_comb begin
    n = r;
    case (r.st)
      pps_pkg::SEQ_IDLE: begin
        if (p.allow) begin
          n.st = pps_pkg::SEQ_PROBE;
        end
      end
      pps_pkg::SEQ_PROBE: begin
        // host-gated ports keep probing until a manual request arrives
        if (p.block_on) begin
          n.st = pps_pkg::SEQ_PROBE;
        end else if (p.power_req) begin
          n.st = pps_pkg::SEQ_FINAL;
        end else if (p.class_ok && p.auto_mode) begin
          n.st = pps_pkg::SEQ_FINAL; // [R1]
        end
      end
      pps_pkg::SEQ_FINAL: begin
        if (p.fault || p.block_on) begin
          n.st = pps_pkg::SEQ_PROBE; // [R3]
        end else if (p.class_ok) begin
          n.st = pps_pkg::SEQ_ON; // [R1]
        end
      end
      pps_pkg::SEQ_ON: begin
        if (p.fault) begin
          n.st = pps_pkg::SEQ_PROBE; // [R3]
        end
      end
      default: begin
        n.st = pps_pkg::SEQ_IDLE;
      end
    endcase
    // nothing runs again until the host sets the allows
    if (!p.allow || p.power_off) begin
      n.st = pps_pkg::SEQ_IDLE; // [R8]
    end
    n.pwr = (n.st == pps_pkg::SEQ_ON);
    n.probe = (n.st == pps_pkg::SEQ_PROBE); // [R2]
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      r <= RST_STATE;
    end else begin
      r <= n;
    end
  end

  assign p.power_on = r.pwr;
  assign p.probing = r.probe;
endmodule

// ==== hdl/pps_ctrl.sv ====
// two-quad port control: shutdown line decoder, two-wire register slave, port sequencers
//
// What this block does
// [R1] Self-running port with both allows powers up after classifying, via final check.
// [R2] Host-gated port keeps probing after classifying and never powers itself.
// [R3] Any fault sends a self-running port back to probing, retried forever.
// [R4] Host writes remap, mask, operating select and allows to both quads.
// [R5] Coded select bit 0 gives single-bit shutdown, 1 gives coded shutdown.
// [R6] Only ports with the low priority tag set are hit by single-bit shutdown.
// [R7] Shutdown rising edge powers off tagged powered ports within 50 us.
// [R8] Shutdown clears allows and measurement data like a manual power-off.
// [R9] While the line is high, tagged ports may not power on.
// [R10] Each port holds a 3-bit rank, 000 highest and 111 lowest.
// [R11] A serial 3-bit code turns off every port with rank at or below it.
// [R12] Code bits last 24 to 26 us, nominal 25 us.
// [R13] Affected ports are off within 50 us of the complete code.
// [R14] Host leaves the line idle 125 us between codes.
// [R15] Two slave addresses, one per quad, each with the same map.
// [R16] Address is 01, four straps, then quad bit, 0x20 to 0x3F.
// [R17] Every transaction opens with START and closes with STOP.
// [R18] Registers take single-byte writes and reads via a pointer byte; status and measurement registers ignore writes.
// [R19] Two-byte read from low byte returns a matched low/high pair.
// [R20] Line is synchronised, rising edge found, code bits sampled mid-period.
`timescale 1ns/10ps
module pps_ctrl (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // two-wire register link
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // address straps
  input wire logic [3:0] address_straps,
  // emergency shutdown
  input wire logic shutdown_line,
  // port front end
  input wire logic [7:0] port_class_ok,
  input wire logic [7:0] port_fault,
  input wire logic [7:0][15:0] port_meas,
  // port power
  output logic [7:0] port_power_on
);
  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_q;
    logic sda_s1;
    logic sda_s2;
    logic sda_q;
    logic shd_s1;
    logic shd_s2;
    logic shd_q;
    logic [3:0] strap_s1;
    logic [3:0] strap_s2;
    pps_pkg::pps_link_t lst;
    logic [2:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic addr_done;
    logic got_ptr;
    logic rd;
    logic quad;
    logic sda_o;
    logic sda_oe_n;
    logic [1:0][7:0] int_mask;
    logic [1:0][7:0] op_sel;
    logic [1:0][7:0] allow;
    logic [1:0][7:0] prio;
    logic [1:0][7:0] misc;
    logic [1:0][7:0] remap;
    logic [1:0][7:0] budget;
    logic [1:0][7:0] rank01;
    logic [1:0][7:0] rank23;
    logic [7:0] meas_hold;
    logic [7:0] meas_valid;
    logic [7:0] kill;
    logic [7:0] man_on;
    logic [7:0] pwr;
    logic [7:0] probing;
    logic sd_busy;
    logic [10:0] sd_timer;
    logic [1:0] sd_bits;
    logic [2:0] sd_code;
  } pps_ctrl_state_t;

  localparam pps_ctrl_state_t RST_STATE = '{lst: pps_pkg::LINK_IDLE, sda_oe_n: 1'b1, default: '0};

  pps_ctrl_state_t r;
  pps_ctrl_state_t n;
  logic [7:0] seq_pwr;
  logic [7:0] seq_probing;

  pps_port_if pif [8] ();

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : g_port
      assign pif[g].auto_mode = (r.op_sel[g / 4][(g % 4) * 2 +: 2] == pps_pkg::MODE_AUTO);
      assign pif[g].allow = r.allow[g / 4][g % 4] & r.allow[g / 4][g % 4 + 4];
      assign pif[g].power_req = r.man_on[g];
      assign pif[g].power_off = r.kill[g];
      // tagged ports stay dark while the line is held high
      assign pif[g].block_on = r.shd_s2 & ~r.misc[g / 4][pps_pkg::MISC_CODED_BIT]
        & r.prio[g / 4][g % 4]; // [R9]
      assign pif[g].class_ok = port_class_ok[g];
      assign pif[g].fault = port_fault[g];
      assign seq_pwr[g] = pif[g].power_on;
      assign seq_probing[g] = pif[g].probing;
      pps_port_seq pps_port_seq_inst (
        .clock(clock),
        .rst(rst),
        .p(pif[g].seq)
      );
    end
  endgenerate

  // register read mux for the addressed quad
  function automatic logic [7:0] read_byte(input pps_ctrl_state_t s,
    input logic [7:0][15:0] meas);
    logic [7:0] v;
    logic [2:0] pidx;
    v = pps_pkg::READ_NONE;
    pidx = {s.quad, s.ptr[2:1]};
    if (s.ptr[7:3] == pps_pkg::REG_MEAS_BASE[7:3]) begin
      // high byte comes from the copy taken with the low byte
      if (!s.meas_valid[pidx]) begin
        v = pps_pkg::READ_NONE; // [R8]
      end else if (s.ptr[0]) begin
        v = s.meas_hold; // [R19]
      end else begin
        v = meas[pidx][7:0];
      end
    end else begin
      case (s.ptr)
        pps_pkg::REG_INT_MASK: v = s.int_mask[s.quad];
        pps_pkg::REG_PWR_STATUS: begin
          v = s.quad ? {s.probing[7:4], s.pwr[7:4]} : {s.probing[3:0], s.pwr[3:0]};
        end
        pps_pkg::REG_OP_SELECT: v = s.op_sel[s.quad];
        pps_pkg::REG_DET_CLASS: v = s.allow[s.quad];
        pps_pkg::REG_PRIO_CUT: v = s.prio[s.quad];
        pps_pkg::REG_MISC: v = s.misc[s.quad];
        pps_pkg::REG_LANE_REMAP: v = s.remap[s.quad];
        pps_pkg::REG_POWER_BUDGET: v = s.budget[s.quad];
        pps_pkg::REG_RANK_01: v = s.rank01[s.quad]; // [R10]
        pps_pkg::REG_RANK_23: v = s.rank23[s.quad];
        default: v = pps_pkg::READ_NONE;
      endcase
    end
    return v;
  endfunction

  always_comb begin
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic shd_rise;
    logic [7:0] rbyte;
    logic [7:0] rdata;
    logic wr_en;
    logic rd_en;
    logic [7:0] man_off;
    logic sd_fire;
    logic [2:0] sd_new;
    logic coded;
    logic tag;
    logic [2:0] rank;
    scl_rise = 1'b0;
    scl_fall = 1'b0;
    start_c = 1'b0;
    stop_c = 1'b0;
    shd_rise = 1'b0;
    rbyte = 8'h00;
    rdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    man_off = 8'h00;
    sd_fire = 1'b0;
    sd_new = 3'h0;
    coded = 1'b0;
    tag = 1'b0;
    rank = 3'h0;
    n = r;
    // pins pass two flops before anything looks at them
    n.scl_s1 = scl_in;
    n.scl_s2 = r.scl_s1;
    n.scl_q = r.scl_s2;
    n.sda_s1 = sda_in;
    n.sda_s2 = r.sda_s1;
    n.sda_q = r.sda_s2;
    n.shd_s1 = shutdown_line;
    n.shd_s2 = r.shd_s1; // [R20]
    n.shd_q = r.shd_s2;
    n.strap_s1 = address_straps;
    n.strap_s2 = r.strap_s1;
    n.sda_o = 1'b0;
    n.kill = 8'h00;
    n.man_on = 8'h00;
    n.pwr = seq_pwr;
    n.probing = seq_probing;
    n.meas_valid = r.meas_valid | (seq_pwr & ~r.kill); // [R8]

    scl_rise = r.scl_s2 & ~r.scl_q;
    scl_fall = ~r.scl_s2 & r.scl_q;
    start_c = r.scl_s2 & r.scl_q & r.sda_q & ~r.sda_s2;
    stop_c = r.scl_s2 & r.scl_q & ~r.sda_q & r.sda_s2;
    shd_rise = r.shd_s2 & ~r.shd_q; // [R20]
    rbyte = {r.shreg[6:0], r.sda_s2};
    rdata = read_byte(r, port_meas);

    // two-wire slave
    if (stop_c) begin
      n.lst = pps_pkg::LINK_IDLE; // [R17]
      n.sda_oe_n = 1'b1;
    end else if (start_c) begin
      // a repeated start keeps the pointer for a following read
      n.lst = pps_pkg::LINK_RX; // [R17]
      n.bitcnt = 3'h0;
      n.addr_done = 1'b0;
      n.got_ptr = 1'b0;
      n.sda_oe_n = 1'b1;
    end else begin
      case (r.lst)
        pps_pkg::LINK_IDLE: begin
          n.lst = pps_pkg::LINK_IDLE;
        end
        pps_pkg::LINK_RX: begin
          if (scl_rise) begin
            n.shreg = rbyte;
            n.bitcnt = r.bitcnt + 3'h1;
            if (r.bitcnt == 3'h7) begin
              n.lst = pps_pkg::LINK_ACK_WAIT;
              if (!r.addr_done) begin
                n.addr_done = 1'b1;
                n.rd = rbyte[0];
                n.quad = rbyte[1]; // [R15]
                if (rbyte[7:2] != {pps_pkg::ADDR_PREFIX, r.strap_s2}) begin
                  n.lst = pps_pkg::LINK_IDLE; // [R16]
                end
              end else if (!r.got_ptr) begin
                n.got_ptr = 1'b1;
                n.ptr = rbyte; // [R18]
              end else begin
                wr_en = 1'b1;
                n.ptr = r.ptr + 8'h01;
              end
            end
          end
        end
        pps_pkg::LINK_ACK_WAIT: begin
          if (scl_fall) begin
            n.sda_oe_n = 1'b0;
            n.lst = pps_pkg::LINK_ACK;
          end
        end
        pps_pkg::LINK_ACK: begin
          if (scl_fall) begin
            n.bitcnt = 3'h0;
            if (r.rd) begin
              rd_en = 1'b1;
              n.shreg = rdata;
              n.sda_oe_n = rdata[7];
              n.ptr = r.ptr + 8'h01; // [R19]
              n.lst = pps_pkg::LINK_TX;
            end else begin
              n.sda_oe_n = 1'b1;
              n.lst = pps_pkg::LINK_RX;
            end
          end
        end
        pps_pkg::LINK_TX: begin
          if (scl_fall) begin
            n.bitcnt = r.bitcnt + 3'h1;
            n.shreg = {r.shreg[6:0], 1'b0};
            n.sda_oe_n = r.shreg[6];
            if (r.bitcnt == 3'h7) begin
              n.sda_oe_n = 1'b1;
              n.lst = pps_pkg::LINK_TX_ACK;
            end
          end
        end
        pps_pkg::LINK_TX_ACK: begin
          if (scl_rise) begin
            n.lst = r.sda_s2 ? pps_pkg::LINK_IDLE : pps_pkg::LINK_ACK;
          end
        end
        default: begin
          n.lst = pps_pkg::LINK_IDLE;
        end
      endcase
    end

    // reading a low measurement byte freezes its partner
    if (rd_en && r.ptr[7:3] == pps_pkg::REG_MEAS_BASE[7:3] && !r.ptr[0]) begin
      n.meas_hold = port_meas[{r.quad, r.ptr[2:1]}][15:8]; // [R19]
    end

    if (wr_en) begin
      case (r.ptr)
        pps_pkg::REG_INT_MASK: n.int_mask[r.quad] = rbyte; // [R4]
        pps_pkg::REG_OP_SELECT: n.op_sel[r.quad] = rbyte; // [R4]
        pps_pkg::REG_DET_CLASS: n.allow[r.quad] = rbyte; // [R4]
        pps_pkg::REG_PRIO_CUT: n.prio[r.quad] = rbyte; // [R6]
        pps_pkg::REG_MISC: n.misc[r.quad] = rbyte & pps_pkg::MISC_MASK; // [R5]
        pps_pkg::REG_LANE_REMAP: n.remap[r.quad] = rbyte; // [R4]
        pps_pkg::REG_POWER_BUDGET: n.budget[r.quad] = rbyte;
        pps_pkg::REG_RANK_01: n.rank01[r.quad] = rbyte & pps_pkg::RANK_MASK; // [R10]
        pps_pkg::REG_RANK_23: n.rank23[r.quad] = rbyte & pps_pkg::RANK_MASK;
        pps_pkg::REG_MAN_POWER: begin
          if (r.quad) begin
            n.man_on[7:4] = rbyte[3:0];
            man_off[7:4] = rbyte[7:4];
          end else begin
            n.man_on[3:0] = rbyte[3:0];
            man_off[3:0] = rbyte[7:4];
          end
        end
        default: begin
          n.ptr = r.ptr + 8'h01;
        end
      endcase
    end

    // coded shutdown receiver: a start bit, then three bits sampled mid-period
    sd_new = {r.sd_code[1:0], r.shd_s2};
    if (!r.sd_busy) begin
      if (shd_rise && (r.misc[0][pps_pkg::MISC_CODED_BIT] || r.misc[1][pps_pkg::MISC_CODED_BIT])) begin
        n.sd_busy = 1'b1;
        n.sd_timer = pps_pkg::SD_FIRST_WAIT; // [R12]
        n.sd_bits = 2'h0;
      end
    end else if (r.sd_timer == 11'h000) begin
      n.sd_code = sd_new; // [R11]
      n.sd_bits = r.sd_bits + 2'h1;
      n.sd_timer = pps_pkg::SD_BIT_WAIT; // [R12]
      if (r.sd_bits == 2'h2) begin
        n.sd_busy = 1'b0;
        sd_fire = 1'b1;
      end
    end else begin
      n.sd_timer = r.sd_timer - 11'h001;
    end

    // shutdown and manual off act one cycle after the cause, far inside 50 us
    for (int i = 0; i < 8; i++) begin
      coded = r.misc[i / 4][pps_pkg::MISC_CODED_BIT]; // [R5]
      tag = r.prio[i / 4][i % 4]; // [R6]
      if ((i % 4) < 2) begin
        rank = r.rank01[i / 4][(i % 2) * 4 +: 3];
      end else begin
        rank = r.rank23[i / 4][(i % 2) * 4 +: 3];
      end
      if (man_off[i] || (shd_rise && !coded && tag && r.pwr[i]) // [R7]
          || (sd_fire && coded && rank >= sd_new)) begin // [R13]
        n.kill[i] = 1'b1; // [R11]
        n.allow[i / 4][i % 4] = 1'b0; // [R8]
        n.allow[i / 4][i % 4 + 4] = 1'b0;
        n.meas_valid[i] = 1'b0;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      r <= RST_STATE;
    end else begin
      r <= n;
    end
  end

  assign sda_out = r.sda_o;
  assign sda_oe_n = r.sda_oe_n;
  assign port_power_on = r.pwr;
endmodule

// ==== tb/pps_host_model.sv ====
// host processor model: two-wire register master and shutdown line driver
`timescale 1ns/10ps
module pps_host_model (
  // clock
  input wire logic clock,
  // two-wire link
  output logic scl = 1'b1,
  output logic sda_low = 1'b0,
  input wire logic sda_wire,
  // shutdown
  output logic shutdown_line = 1'b0,
  // read data seen by the host
  output logic rd_valid = 1'b0,
  output logic [7:0] rd_data = 8'h00
);
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  // data only moves while the clock is low
  task automatic put_bit(input logic b);
    scl <= 1'b0;
    tick(3);
    sda_low <= !b;
    tick(5);
    scl <= 1'b1;
    tick(8);
  endtask
  task automatic get_bit(output logic b);
    scl <= 1'b0;
    tick(3);
    sda_low <= 1'b0;
    tick(5);
    scl <= 1'b1;
    tick(4);
    b = sda_wire;
    tick(4);
  endtask
  task automatic put_byte(input logic [7:0] v);
    logic a;
    for (int i = 7; i >= 0; i--) put_bit(v[i]);
    get_bit(a);
  endtask
  // also serves as repeated start, so the slave's ack is let go first
  task automatic start;
    scl <= 1'b0;
    tick(8);
    sda_low <= 1'b0;
    tick(4);
    scl <= 1'b1;
    tick(8);
    sda_low <= 1'b1;
    tick(8);
  endtask
  task automatic stop;
    scl <= 1'b0;
    tick(4);
    sda_low <= 1'b1;
    tick(4);
    scl <= 1'b1;
    tick(8);
    sda_low <= 1'b0;
    tick(16);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] r, input logic [7:0] d);
    start();
    put_byte({a, 1'b0});
    put_byte(r);
    put_byte(d);
    stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] r, input int n);
    logic [7:0] v;
    start();
    put_byte({a, 1'b0});
    put_byte(r);
    start();
    put_byte({a, 1'b1});
    for (int k = 0; k < n; k++) begin
      for (int i = 7; i >= 0; i--) get_bit(v[i]);
      put_bit(k == n - 1);
      rd_data <= v;
      rd_valid <= 1'b1;
      tick(1);
      rd_valid <= 1'b0;
    end
    stop();
  endtask
  task automatic hold(input logic v);
    shutdown_line <= v;
  endtask
  // start bit, then code msb first, then the idle gap
  task automatic send_code(input logic [2:0] c, input int per);
    shutdown_line <= 1'b1;
    tick(per);
    for (int i = 2; i >= 0; i--) begin
      shutdown_line <= c[i];
      tick(per);
    end
    shutdown_line <= 1'b0;
    tick(5000);
  endtask
endmodule

// ==== tb/pps_ctrl_properties.sv ====
// concurrent checks on the ports of the shutdown and register control top
`timescale 1ns/10ps
module pps_ctrl_properties (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // two-wire link
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // straps and shutdown
  input wire logic [3:0] address_straps,
  input wire logic shutdown_line,
  // ports
  input wire logic [7:0] port_class_ok,
  input wire logic [7:0] port_fault,
  input wire logic [7:0][15:0] port_meas,
  input wire logic [7:0] port_power_on
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic [12:0] sd_age_r;
  logic [12:0] lk_age_r;
  // ages since the shutdown line was last high and since the link lines last differed, saturating
  always_ff @(posedge clock or posedge rst) begin
    if (rst || shutdown_line) sd_age_r <= 13'h0000;
    else if (sd_age_r != 13'h1FFF) sd_age_r <= sd_age_r + 13'h0001;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst || scl_in != sda_in) lk_age_r <= 13'h0000;
    else if (lk_age_r != 13'h1FFF) lk_age_r <= lk_age_r + 13'h0001;
  end
  property p_rst_power;
    $past(rst) |-> port_power_on == 8'h00;
  endproperty
  a_rst_power: assert property (p_rst_power) else $error("port powered right after reset");
  property p_rst_link;
    $past(rst) |-> sda_oe_n;
  endproperty
  a_rst_link: assert property (p_rst_link) else $error("data pin driven right after reset");
  property p_open_drain;
    !sda_oe_n |-> !sda_out;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("data pin driven high");
  property p_quiet_scl_high;
    scl_in && $past(scl_in) && $past(scl_in, 2) && $past(scl_in, 3) |-> $stable(sda_oe_n);
  endproperty
  a_quiet_scl_high: assert property (p_quiet_scl_high) else $error("data moved while clock high");
  property p_change_scl_low;
    $changed(sda_oe_n) |-> !scl_in && !$past(scl_in, 2);
  endproperty
  a_change_scl_low: assert property (p_change_scl_low) else $error("data change not in clock low");
  property p_on_needs_class;
    (port_power_on & ~$past(port_power_on) & ~$past(port_class_ok)) == 8'h00;
  endproperty
  a_on_needs_class: assert property (p_on_needs_class) else $error("port powered without class");
  property p_fault_kills;
    (port_fault & $past(port_fault) & $past(port_fault, 2) & port_power_on) == 8'h00;
  endproperty
  a_fault_kills: assert property (p_fault_kills) else $error("faulted port still powered");
  property p_off_has_cause;
    ($past(port_power_on) & ~port_power_on) != 8'h00 |->
      $past(port_fault) != 8'h00 || sd_age_r < 13'hFA0 || lk_age_r < 13'h040;
  endproperty
  a_off_has_cause: assert property (p_off_has_cause) else $error("port dropped without cause");
  c_shutdown: cover property ($rose(shutdown_line));
  c_ack: cover property ($fell(sda_oe_n));
  c_power: cover property ($rose(|port_power_on));
endmodule

// ==== tb/pps_ctrl_tb.sv ====
// testbench for the port shutdown and register control block
`timescale 1ns/10ps
module pps_ctrl_tb;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [3:0] address_straps = 4'h0;
  logic [7:0] port_class_ok = 8'h00;
  logic [7:0] port_fault = 8'h00;
  logic [7:0][15:0] port_meas = '0;
  logic scl, sda_low, sda_wire, shutdown_line, sda_out, sda_oe_n, rd_valid;
  logic [7:0] port_power_on, rd_data;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h9F03;
  int mismatches = 0;
  int samples_checked = 0;
  always #12.5 clock = ~clock;
  // pulled up whenever no party pulls low
  assign sda_wire = (sda_low || (!sda_oe_n && !sda_out)) ? 1'b0 : 1'b1;
  pps_ctrl pps_ctrl_inst (.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .address_straps(address_straps), .shutdown_line(shutdown_line),
    .port_class_ok(port_class_ok), .port_fault(port_fault), .port_meas(port_meas), .port_power_on(port_power_on));
  pps_host_model pps_host_model_inst (.clock(clock), .scl(scl), .sda_low(sda_low), .sda_wire(sda_wire),
    .shutdown_line(shutdown_line), .rd_valid(rd_valid), .rd_data(rd_data));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [6:0] adr(input logic q);
    return {2'b01, address_straps, q};
  endfunction
  task automatic note(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic chk(input logic q, input logic [7:0] r, input logic [7:0] e);
    exp_q.push_back(e);
    pps_host_model_inst.rd(adr(q), r, 1);
  endtask
  task automatic put(input logic q, input logic [7:0] r, input logic [7:0] d);
    pps_host_model_inst.wr(adr(q), r, d);
  endtask
  task automatic give_verdict;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) note(rd_data, (rd_data === 8'h00) ? 8'hFF : 8'h00);
      else note(rd_data, exp_q.pop_front());
    end
  end
  initial begin
    seed = lfsr(seed);
    address_straps <= seed[3:0];
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      port_meas[i] <= seed[15:0];
    end
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    chk(1'b0, pps_pkg::REG_POWER_BUDGET, 8'h00);
    put(1'b1, pps_pkg::REG_POWER_BUDGET, 8'h5A);
    chk(1'b1, pps_pkg::REG_POWER_BUDGET, 8'h5A);
    chk(1'b0, pps_pkg::REG_POWER_BUDGET, 8'h00);
    pps_host_model_inst.wr({2'b01, ~address_straps, 1'b0}, pps_pkg::REG_POWER_BUDGET, 8'h33);
    chk(1'b0, pps_pkg::REG_POWER_BUDGET, 8'h00);
    put(1'b0, pps_pkg::REG_PWR_STATUS, 8'hFF);
    chk(1'b0, pps_pkg::REG_PWR_STATUS, 8'h00);
    chk(1'b0, 8'h7E, 8'h00);
    $display("test map done");
    port_class_ok <= 8'hFF;
    for (int q = 0; q < 2; q++) begin
      put(q[0], pps_pkg::REG_LANE_REMAP, 8'hE4);
      put(q[0], pps_pkg::REG_INT_MASK, 8'hE4);
      put(q[0], pps_pkg::REG_OP_SELECT, 8'hFF);
      put(q[0], pps_pkg::REG_DET_CLASS, 8'hFF);
      chk(q[0], pps_pkg::REG_PWR_STATUS, 8'h0F);
    end
    chk(1'b0, pps_pkg::REG_LANE_REMAP, 8'hE4);
    $display("test auto done");
    port_fault <= 8'h02;
    port_class_ok <= 8'hFD;
    chk(1'b0, pps_pkg::REG_PWR_STATUS, 8'h2D);
    port_fault <= 8'h00;
    port_class_ok <= 8'hFF;
    chk(1'b0, pps_pkg::REG_PWR_STATUS, 8'h0F);
    exp_q.push_back(port_meas[4][7:0]);
    exp_q.push_back(port_meas[4][15:8]);
    pps_host_model_inst.rd(adr(1'b1), pps_pkg::REG_MEAS_BASE, 2);
    $display("test fault done");
    put(1'b0, pps_pkg::REG_MAN_POWER, 8'hF0);
    chk(1'b0, pps_pkg::REG_DET_CLASS, 8'h00);
    chk(1'b0, pps_pkg::REG_MEAS_BASE, 8'h00);
    put(1'b0, pps_pkg::REG_OP_SELECT, 8'h00);
    put(1'b0, pps_pkg::REG_DET_CLASS, 8'hFF);
    chk(1'b0, pps_pkg::REG_PWR_STATUS, 8'hF0);
    put(1'b0, pps_pkg::REG_MAN_POWER, 8'h01);
    chk(1'b0, pps_pkg::REG_PWR_STATUS, 8'hE1);
    $display("test gated done");
    put(1'b0, pps_pkg::REG_PRIO_CUT, 8'h01);
    pps_host_model_inst.hold(1'b1);
    repeat (2000) @(posedge clock);
    chk(1'b0, pps_pkg::REG_PWR_STATUS, 8'hE0);
    chk(1'b0, pps_pkg::REG_DET_CLASS, 8'hEE);
    chk(1'b1, pps_pkg::REG_PWR_STATUS, 8'h0F);
    put(1'b0, pps_pkg::REG_DET_CLASS, 8'hFF);
    put(1'b0, pps_pkg::REG_MAN_POWER, 8'h01);
    chk(1'b0, pps_pkg::REG_PWR_STATUS, 8'hF0);
    pps_host_model_inst.hold(1'b0);
    put(1'b0, pps_pkg::REG_MAN_POWER, 8'h01);
    chk(1'b0, pps_pkg::REG_PWR_STATUS, 8'hE1);
    $display("test single-bit done");
    put(1'b1, pps_pkg::REG_MISC, 8'h01);
    put(1'b1, pps_pkg::REG_RANK_01, 8'h52);
    put(1'b1, pps_pkg::REG_RANK_23, 8'h70);
    chk(1'b1, pps_pkg::REG_RANK_01, 8'h52);
    pps_host_model_inst.send_code(3'h5, 960);
    chk(1'b1, pps_pkg::REG_PWR_STATUS, 8'h05);
    chk(1'b1, pps_pkg::REG_DET_CLASS, 8'h55);
    chk(1'b0, pps_pkg::REG_PWR_STATUS, 8'hE0);
    $display("test coded done");
    give_verdict();
  end
  initial begin
    repeat (90000) @(posedge clock);
    mismatches++;
    give_verdict();
  end
endmodule
bind pps_ctrl pps_ctrl_properties pps_ctrl_properties_inst (.clock(clock), .rst(rst), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .address_straps(address_straps),
  .shutdown_line(shutdown_line), .port_class_ok(port_class_ok), .port_fault(port_fault),
  .port_meas(port_meas), .port_power_on(port_power_on));
